// ---- hdl/fct_clock_status.sv ----
/*
  Register side of a frequency-locked-loop clock generator: control, loop ratio, flags, reference
  trim, factory test register and a maskable event interrupt, all behind a classic Wishbone slave.
  Assumes one 125 MHz clock, synchronous inputs, and power-on and system resets that are both
  synchronous and active high.
*/
// How it works
// R01: Loop factor is 1000 plus twice the 7-bit ratio field, 1000 to 1254.
// R02: A write to the ratio register clears lock state without a change flag.
// R03: Power-on flag bit 6 sets on power-on; writing one clears, zero keeps.
// R04: System reset leaves the power-on flag untouched.
// R05: Bad-access flag bit 2 sets on illegal access, write-one clear, power-on clears.
// R06: Lock change flag bit 4 sets on every lock state edge except a forced clear; write-one clear.
// R07: With lock interrupt enable set, a set lock change flag requests an interrupt.
// R08: Stop mode or writes to control 0, ratio or trim clear lock state silently.
// R09: Lock state bit 3 shows in-tolerance status; writes are ignored.
// R10: Oscillator started bit 1 sets after startup; disable or stop clears it.
// R11: Oscillator may feed bus clock or loop reference only once it has started.
// R12: Oscillator monitor is active only while the started bit is set.
// R13: After system reset the 9-bit trim loads the factory value from flash.
// R14: Trim is binary weighted; a lower value gives a higher reference frequency.
// R15: Factory test register is always readable and ignores all writes.
// R16: Reference select zero picks the internal reference, one the divided oscillator.
// R17: Lock interrupt enable gates the request raised by the lock change flag.
// R18: A new lock change in the cycle of its write-one clear keeps the flag set.
// R19: Reserved bits of the flags and trim high registers read zero.
`timescale 1ns/10ps
module fct_clock_status #(
  parameter logic [7:0] TEST0_VALUE = 8'h00
) (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [fct_pkg::ADR_W-1:0] adr_i,
  input wire logic [fct_pkg::SEL_W-1:0] sel_i,
  input wire logic [fct_pkg::DAT_W-1:0] dat_i,
  output logic [fct_pkg::DAT_W-1:0] dat_o,
  output logic ack_o,
  // Clock system status
  input wire logic stop_mode_i,
  input wire logic fll_in_tol_i,
  input wire logic osc_ready_i,
  input wire logic bad_access_i,
  input wire logic [fct_pkg::TRIM_W-1:0] trim_factory_i,
  // Clock system control and interrupt
  output fct_pkg::fct_clk_cfg_t clk_cfg_o,
  output logic irq_o
);
  import fct_pkg::*;

  fct_ctl0_t ctl0_reg;
  fct_ctl0_t ctl0_next;
  logic [3:0] bdiv_reg;
  logic lock_irq_enable_reg;
  logic [RATIO_W-1:0] dco_ratio_field_reg;
  logic [TRIM_W-1:0] trim_reg;
  logic trim_pend_reg;
  logic power_on_flag_reg;
  logic bad_access_flag_reg;
  logic lock_change_flag_reg;
  logic lock_state_bit_reg;
  logic osc_started_bit_reg;
  logic [EVT_W-1:0] evt_reg;
  logic [EVT_W-1:0] mask_reg;
  logic ack_reg;
  logic [DAT_W-1:0] dat_reg;

  // Bus decode. The write lands on the edge where the master sees ack.
  wire bus_req = cyc_i & stb_i;
  wire rd_fire = bus_req & ~ack_reg;
  wire wr_fire = bus_req & we_i & ack_reg & sel_i[0];
  wire [7:0] wb = dat_i[7:0];
  wire sel_ctl0 = adr_i == fct_reg_addr(IDX_CTL0);
  wire sel_ctl1 = adr_i == fct_reg_addr(IDX_CTL1);
  wire sel_dco_ratio_field = adr_i == fct_reg_addr(IDX_DCO_RATIO_FIELD);
  wire sel_flags = adr_i == fct_reg_addr(IDX_FLAGS);
  wire sel_trimh = adr_i == fct_reg_addr(IDX_TRIMH);
  wire sel_triml = adr_i == fct_reg_addr(IDX_TRIML);
  wire sel_test0 = adr_i == fct_reg_addr(IDX_TEST0);
  wire sel_stat = adr_i == fct_reg_addr(IDX_EVT_STAT);
  wire sel_mask = adr_i == fct_reg_addr(IDX_EVT_MASK);
  wire wr_ctl0 = wr_fire & sel_ctl0;
  wire wr_ctl1 = wr_fire & sel_ctl1;
  wire wr_dco_ratio_field = wr_fire & sel_dco_ratio_field;
  wire wr_flags = wr_fire & sel_flags;
  wire wr_trimh = wr_fire & sel_trimh;
  wire wr_triml = wr_fire & sel_triml;
  wire wr_stat = wr_fire & sel_stat;
  wire wr_mask = wr_fire & sel_mask;

  // Lock tracking. A forced clear is not a lock change, so it never sets the flag.
  wire lock_clear = stop_mode_i | wr_ctl0 | wr_dco_ratio_field | wr_trimh | wr_triml; // see R08
  wire lock_state_next = lock_clear ? 1'b0 : fll_in_tol_i; // see R09
  wire lock_changed = ~lock_clear & (lock_state_next != lock_state_bit_reg); // see R06
  wire lock_flag_clr = wr_flags & wb[FLG_LOCK_CHG];
  wire lock_flag_next = lock_changed | (lock_change_flag_reg & ~lock_flag_clr); // see R18

  wire osc_off = ~ctl0_reg.osc_en | stop_mode_i;
  wire osc_started_next = ~osc_off & (osc_started_bit_reg | osc_ready_i); // see R10

  wire por_flag_next = por_i | (power_on_flag_reg & ~(wr_flags & wb[FLG_POWER_ON])); // see R03
  wire bad_flag_next = bad_access_i | (bad_access_flag_reg & ~(wr_flags & wb[FLG_BAD_ACC])); // see R05

  wire [EVT_W-1:0] evt_set = {osc_started_next & ~osc_started_bit_reg, bad_access_i, lock_changed};
  wire [EVT_W-1:0] evt_clr = wr_stat ? wb[EVT_W-1:0] : {EVT_W{1'b0}};
  wire [EVT_W-1:0] evt_next = evt_set | (evt_reg & ~evt_clr);

  // Oscillator-derived selections need a started oscillator and drop when it stops.
  always_comb begin
    ctl0_next = ctl0_reg;
    if (wr_ctl0) begin
      ctl0_next.osc_en = wb[7];
      ctl0_next.ref_divider = wb[6:4];
      ctl0_next.bus_clk_source_sel = wb[3] & osc_started_bit_reg; // see R11
      ctl0_next.loop_reference_select = wb[2] & osc_started_bit_reg; // see R11
      // The filter choice is frozen once the oscillator is enabled.
      if (!ctl0_reg.osc_en) begin
        ctl0_next.osc_low_bw = wb[1];
      end
    end
    if (!ctl0_next.osc_en || stop_mode_i) begin
      ctl0_next.bus_clk_source_sel = 1'b0;
      ctl0_next.loop_reference_select = 1'b0;
    end
  end

  wire [7:0] flags_rd = {1'b0, power_on_flag_reg, 1'b0, lock_change_flag_reg,
                         lock_state_bit_reg, bad_access_flag_reg, osc_started_bit_reg, 1'b0};
  wire [7:0] ctl1_rd = {bdiv_reg, 2'b00, lock_irq_enable_reg, 1'b0};
  wire [7:0] rd_byte = sel_ctl0 ? {ctl0_reg[7:1], 1'b0} :
                       sel_ctl1 ? ctl1_rd :
                       sel_dco_ratio_field ? {1'b0, dco_ratio_field_reg} :
                       sel_flags ? flags_rd : // see R19
                       sel_trimh ? {7'h00, trim_reg[TRIM_W-1]} : // see R19
                       sel_triml ? trim_reg[7:0] :
                       sel_test0 ? TEST0_VALUE : // see R15
                       sel_stat ? {5'h00, evt_reg} :
                       sel_mask ? {5'h00, mask_reg} :
                       8'h00;

  // Bus handshake: one wait state, then ack for exactly one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= rd_fire;
      if (rd_fire) begin
        dat_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Power-on reset is the only reset that touches the sticky reset flags.
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      power_on_flag_reg <= 1'b1; // see R03
      bad_access_flag_reg <= 1'b0; // see R05
    end else begin
      power_on_flag_reg <= por_flag_next; // see R04
      bad_access_flag_reg <= bad_flag_next; // see R05
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      ctl0_reg <= CTL0_RST;
      bdiv_reg <= BDIV_RST;
      lock_irq_enable_reg <= 1'b0;
      dco_ratio_field_reg <= {RATIO_W{1'b0}};
      lock_change_flag_reg <= 1'b0;
      lock_state_bit_reg <= 1'b0;
      osc_started_bit_reg <= 1'b0;
      evt_reg <= {EVT_W{1'b0}};
      mask_reg <= {EVT_W{1'b0}};
    end else begin
      ctl0_reg <= ctl0_next;
      if (wr_ctl1) begin
        bdiv_reg <= wb[7:CTL1_BDIV_LSB];
        lock_irq_enable_reg <= wb[CTL1_LOCK_IE];
      end
      if (wr_dco_ratio_field) begin
        dco_ratio_field_reg <= wb[RATIO_W-1:0];
      end
      if (wr_mask) begin
        mask_reg <= wb[EVT_W-1:0];
      end
      lock_change_flag_reg <= lock_flag_next; // see R06
      lock_state_bit_reg <= lock_state_next; // see R02
      osc_started_bit_reg <= osc_started_next;
      evt_reg <= evt_next;
    end
  end

  // The factory trim lands on the first edge after reset release, before any bus write can.
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      trim_reg <= TRIM_RST;
      trim_pend_reg <= 1'b1;
    end else if (trim_pend_reg) begin
      trim_reg <= trim_factory_i; // see R13
      trim_pend_reg <= 1'b0;
    end else begin
      if (wr_trimh) begin
        trim_reg[TRIM_W-1] <= wb[0];
      end
      if (wr_triml) begin
        trim_reg[7:0] <= wb;
      end
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign irq_o = (lock_change_flag_reg & lock_irq_enable_reg) | (|(evt_reg & mask_reg)); // see R07 see R17

  assign clk_cfg_o.osc_enable = ctl0_reg.osc_en;
  assign clk_cfg_o.osc_monitor_en = ctl0_reg.osc_en & osc_started_bit_reg; // see R12
  assign clk_cfg_o.bus_clk_source_sel = ctl0_reg.bus_clk_source_sel;
  assign clk_cfg_o.loop_reference_select = ctl0_reg.loop_reference_select; // see R16
  assign clk_cfg_o.osc_low_bw = ctl0_reg.osc_low_bw;
  assign clk_cfg_o.ref_divider = ctl0_reg.ref_divider;
  assign clk_cfg_o.bus_divider = bdiv_reg;
  assign clk_cfg_o.dco_ratio = fct_ratio(dco_ratio_field_reg); // see R01
  // Passed straight to the analog trim; binary weighted, lower code means faster.
  assign clk_cfg_o.ref_trim = trim_reg; // see R14

  default clocking cb @(posedge clk_i);
  endclocking

  a_ratio_write: assert property (disable iff (rst_i || por_i) // see R01
    wr_dco_ratio_field |=> clk_cfg_o.dco_ratio == RATIO_BASE + {3'h0, $past(dat_i[RATIO_W-1:0]), 1'b0})
    else $error("Loop factor does not follow the written ratio.");

  a_ratio_range: assert property (disable iff (rst_i || por_i) // see R01
    clk_cfg_o.dco_ratio >= 11'h3e8 && clk_cfg_o.dco_ratio <= 11'h4e6)
    else $error("Loop factor outside 1000 to 1254.");

  a_dco_ratio_field_silent: assert property (disable iff (rst_i || por_i) // see R02
    wr_dco_ratio_field && !wr_flags |=> !lock_state_bit_reg && lock_change_flag_reg == $past(lock_change_flag_reg))
    else $error("Ratio write did not clear lock state silently.");

  a_por_sets: assert property (por_i |=> power_on_flag_reg && !bad_access_flag_reg) // see R03
    else $error("Power-on did not set power flag or clear bad-access flag.");

  a_sysrst_keeps: assert property (disable iff (por_i) // see R04
    rst_i |=> power_on_flag_reg == $past(power_on_flag_reg) && bad_access_flag_reg == $past(bad_access_flag_reg))
    else $error("System reset changed a sticky reset flag.");

  a_bad_access: assert property (disable iff (por_i) // see R05
    bad_access_i |=> bad_access_flag_reg)
    else $error("Illegal access did not set its flag.");

  a_lock_flag: assert property (disable iff (rst_i || por_i) // see R18
    lock_changed && lock_flag_clr |=> lock_change_flag_reg)
    else $error("Lock change lost against a clear.");

  a_lock_irq: assert property (disable iff (rst_i || por_i) // see R07
    lock_change_flag_reg && lock_irq_enable_reg |-> irq_o)
    else $error("Enabled lock change did not request an interrupt.");

  a_stop_clears: assert property (disable iff (rst_i || por_i) // see R08
    stop_mode_i |=> !lock_state_bit_reg && !osc_started_bit_reg && !clk_cfg_o.bus_clk_source_sel)
    else $error("Stop mode left lock or oscillator state set.");

  a_lock_track: assert property (disable iff (rst_i || por_i) // see R09
    !lock_clear |=> lock_state_bit_reg == $past(fll_in_tol_i))
    else $error("Lock state does not follow the tolerance detector.");

  a_osc_guard: assert property (disable iff (rst_i || por_i) // see R11
    wr_ctl0 && !osc_started_bit_reg |=> !clk_cfg_o.bus_clk_source_sel && !clk_cfg_o.loop_reference_select)
    else $error("Oscillator selected before startup finished.");

  a_monitor_gate: assert property (disable iff (rst_i || por_i) // see R12
    clk_cfg_o.osc_monitor_en |-> osc_started_bit_reg)
    else $error("Oscillator monitor active before startup.");

  a_trim_load: assert property (disable iff (rst_i || por_i) // see R13
    trim_pend_reg |=> clk_cfg_o.ref_trim == $past(trim_factory_i) && !trim_pend_reg)
    else $error("Factory trim not loaded after reset release.");

  a_test_read: assert property (disable iff (rst_i || por_i) // see R15
    rd_fire && sel_test0 |=> ack_o && dat_o == {24'h00_0000, TEST0_VALUE})
    else $error("Test register read returned a wrong value.");

  a_trimh_rsvd: assert property (disable iff (rst_i || por_i) // see R19
    rd_fire && (sel_trimh || sel_flags) |=> dat_o[DAT_W-1:8] == 24'h00_0000 && !dat_o[7] &&
      !(sel_trimh && |dat_o[7:1]))
    else $error("Reserved bits read non-zero.");

  // A missing ack stalls the master for good, and a stretched one would answer a second request.
  a_ack_answer: assert property (disable iff (rst_i || por_i)
    bus_req && !ack_o |=> ack_o)
    else $error("Bus request not answered after one wait state.");

  a_ack_pulse: assert property (disable iff (rst_i || por_i)
    ack_o |=> !ack_o)
    else $error("Bus acknowledge stood longer than one cycle.");

  // The sticky reset flags answer only to power-on, to software write-one clears and, for the bad-access flag, to an illegal access.
  a_por_clear: assert property (disable iff (por_i) // see R03
    wr_flags && wb[FLG_POWER_ON] |=> !power_on_flag_reg)
    else $error("Write of one did not clear the power flag.");

  a_por_keep: assert property (disable iff (por_i) // see R04
    power_on_flag_reg && !(wr_flags && wb[FLG_POWER_ON]) |=> power_on_flag_reg)
    else $error("Power flag lost without a write of one.");

  a_bad_clear: assert property (disable iff (por_i) // see R05
    wr_flags && wb[FLG_BAD_ACC] && !bad_access_i |=> !bad_access_flag_reg)
    else $error("Write of one did not clear the bad-access flag.");

  a_bad_keep: assert property (disable iff (por_i) // see R05
    bad_access_flag_reg && !(wr_flags && wb[FLG_BAD_ACC]) |=> bad_access_flag_reg)
    else $error("Bad-access flag lost without a write of one.");

  // Forced clears are kept out of the change detection, so only true lock edges raise the flag.
  a_lock_set: assert property (disable iff (rst_i || por_i) // see R06
    !lock_clear && fll_in_tol_i != lock_state_bit_reg |=> lock_change_flag_reg)
    else $error("Lock state change did not set the change flag.");

  a_lock_keep: assert property (disable iff (rst_i || por_i) // see R06
    lock_change_flag_reg && !lock_flag_clr |=> lock_change_flag_reg)
    else $error("Lock change flag lost without a write of one.");

  a_lock_w1c: assert property (disable iff (rst_i || por_i) // see R06
    lock_flag_clr && (lock_clear || fll_in_tol_i == lock_state_bit_reg) |=> !lock_change_flag_reg)
    else $error("Write of one did not clear the lock change flag.");

  a_lock_state_bit_ro: assert property (disable iff (rst_i || por_i) // see R09
    wr_flags && !fll_in_tol_i |=> !lock_state_bit_reg)
    else $error("A flags write set the lock state.");

  // Oscillator status and the selections that depend on it.
  a_osc_drop: assert property (disable iff (rst_i || por_i) // see R10
    !clk_cfg_o.osc_enable |=> !osc_started_bit_reg)
    else $error("Started bit stayed set with the oscillator disabled.");

  a_osc_start: assert property (disable iff (rst_i || por_i) // see R10
    clk_cfg_o.osc_enable && !stop_mode_i && osc_ready_i |=> osc_started_bit_reg)
    else $error("Started bit missing after oscillator startup.");

  a_sel_drop: assert property (disable iff (rst_i || por_i) // see R11
    !clk_cfg_o.osc_enable |-> !clk_cfg_o.bus_clk_source_sel && !clk_cfg_o.loop_reference_select)
    else $error("Oscillator selected while disabled.");

  a_stop_monitor: assert property (disable iff (rst_i || por_i) // see R12
    stop_mode_i |=> !clk_cfg_o.osc_monitor_en)
    else $error("Oscillator monitor active after stop.");

  // The trim moves only through the reload after reset or a software write.
  a_trim_hold: assert property (disable iff (rst_i || por_i) // see R13
    !trim_pend_reg && !wr_trimh && !wr_triml |=> clk_cfg_o.ref_trim == $past(clk_cfg_o.ref_trim))
    else $error("Trim changed without a write.");

  a_trim_low: assert property (disable iff (rst_i || por_i) // see R14
    wr_triml && !trim_pend_reg |=> clk_cfg_o.ref_trim[7:0] == $past(dat_i[7:0]))
    else $error("Trim low byte does not follow the written value.");

  a_irq_quiet: assert property (disable iff (rst_i || por_i) // see R17
    !lock_irq_enable_reg && !(|(evt_reg & mask_reg)) |-> !irq_o)
    else $error("Interrupt raised with every source gated.");

  a_evt_irq: assert property (disable iff (rst_i || por_i)
    |(evt_reg & mask_reg) |-> irq_o)
    else $error("Unmasked event did not request an interrupt.");

  a_flags_rsvd: assert property (disable iff (rst_i || por_i) // see R19
    rd_fire && sel_flags |=> !dat_o[7] && !dat_o[5] && !dat_o[0])
    else $error("Reserved flag bits read non-zero.");

endmodule : fct_clock_status

// ---- hdl/fct_pkg.sv ----
/*
  Shared constants, types and helpers of the clock status and trim block.
  Assumes a byte-addressed 32-bit classic Wishbone bus with each register in one aligned word.
*/
package fct_pkg;

  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int RATIO_W = 7;
  localparam int TRIM_W = 9;
  localparam int FACT_W = 11;
  localparam int EVT_W = 3;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_CTL0 = 8'h34;
  localparam logic [7:0] IDX_CTL1 = 8'h35;
  localparam logic [7:0] IDX_DCO_RATIO_FIELD = 8'h36;
  localparam logic [7:0] IDX_FLAGS = 8'h37;
  localparam logic [7:0] IDX_TRIMH = 8'h38;
  localparam logic [7:0] IDX_TRIML = 8'h39;
  localparam logic [7:0] IDX_TEST0 = 8'h3a;
  localparam logic [7:0] IDX_EVT_STAT = 8'h3c;
  localparam logic [7:0] IDX_EVT_MASK = 8'h3d;

  // Flags register bit positions.
  localparam int FLG_POWER_ON = 6;
  localparam int FLG_LOCK_CHG = 4;
  localparam int FLG_LOCK_ST = 3;
  localparam int FLG_BAD_ACC = 2;
  localparam int FLG_OSC_UP = 1;

  // Control register 1 fields.
  localparam int CTL1_BDIV_LSB = 4;
  localparam int CTL1_LOCK_IE = 1;

  // Event status and mask bit positions.
  localparam int EVT_LOCK = 0;
  localparam int EVT_BAD = 1;
  localparam int EVT_OSC = 2;

  localparam logic [FACT_W-1:0] RATIO_BASE = 11'h3e8;
  localparam logic [TRIM_W-1:0] TRIM_RST = 9'h000;
  localparam logic [7:0] CTL0_RST = 8'h00;
  localparam logic [3:0] BDIV_RST = 4'h0;

  typedef struct packed {
    logic osc_en;
    logic [2:0] ref_divider;
    logic bus_clk_source_sel;
    logic loop_reference_select;
    logic osc_low_bw;
    logic spare;
  } fct_ctl0_t;

  typedef struct packed {
    logic osc_enable;
    logic osc_monitor_en;
    logic bus_clk_source_sel;
    logic loop_reference_select;
    logic osc_low_bw;
    logic [2:0] ref_divider;
    logic [3:0] bus_divider;
    logic [FACT_W-1:0] dco_ratio;
    logic [TRIM_W-1:0] ref_trim;
  } fct_clk_cfg_t;

  function automatic logic [ADR_W-1:0] fct_reg_addr(input logic [7:0] idx);
    fct_reg_addr = {idx[5:0], 2'b00};
  endfunction : fct_reg_addr

  function automatic logic [FACT_W-1:0] fct_ratio(input logic [RATIO_W-1:0] field);
    fct_ratio = RATIO_BASE + {3'h0, field, 1'b0};
  endfunction : fct_ratio

endpackage : fct_pkg

// ---- tb/test_fct_clock_status.sv ----
/*
  Self-checking bench for the clock status and trim block: reads are noted in a queue and
  compared by a watcher on ack_o, port values are compared directly.
  Assumes the register map and one-cycle Wishbone answer described for fct_clock_status.
*/
`timescale 1ns/10ps
module test_fct_clock_status;
  import fct_pkg::*;
  logic clk_i, rst_i, por_i, cyc_i, stb_i, we_i, ack_o, irq_o;
  logic stop_mode_i, fll_in_tol_i, osc_ready_i, bad_access_i;
  logic [ADR_W-1:0] adr_i;
  logic [SEL_W-1:0] sel_i;
  logic [DAT_W-1:0] dat_i;
  logic [DAT_W-1:0] dat_o;
  logic [TRIM_W-1:0] trim_factory_i;
  logic [7:0] v;
  logic [7:0] regs [4];
  fct_clk_cfg_t clk_cfg_o;
  logic [DAT_W-1:0] exp_q[$];
  string name_q[$];
  int err_total, n_compared, cycles;
  int r;

  fct_clock_status u_dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .stop_mode_i(stop_mode_i), .fll_in_tol_i(fll_in_tol_i), .osc_ready_i(osc_ready_i),
    .bad_access_i(bad_access_i), .trim_factory_i(trim_factory_i), .clk_cfg_o(clk_cfg_o), .irq_o(irq_o));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic final_report();
    if (exp_q.size() != 0) err_total++;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic compare(input string what, input logic [DAT_W-1:0] exp, input logic [DAT_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : compare

  // One classic cycle; tgl flips the tolerance input at the first waiting edge.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s,
                     input bit tgl);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx[5:0], 2'b00};
    sel_i <= s;
    dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      if (tgl && n == 0) fll_in_tol_i <= ~fll_in_tol_i;
      n++;
    end while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hf, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string what);
    exp_q.push_back({24'h0, e});
    name_q.push_back(what);
    bus(1'b0, idx, 8'h00, 4'hf, 1'b0);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // The watcher takes the oldest note whenever a read is answered.
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      compare(name_q.pop_front(), exp_q.pop_front(), dat_o);
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    {cyc_i, stb_i, we_i, stop_mode_i, fll_in_tol_i, osc_ready_i, bad_access_i} = '0;
    adr_i = '0;
    sel_i = '0;
    dat_i = '0;
    void'($urandom(17959));
    trim_factory_i = 9'($urandom);
    rst_i = 1'b1;
    por_i = 1'b1;
    tick(3);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    rd(IDX_FLAGS, 8'h40, "flags after power-on");
    rd(IDX_TRIMH, {7'h0, trim_factory_i[8]}, "trim high");
    rd(IDX_TRIML, trim_factory_i[7:0], "trim low");
    wr(IDX_TEST0, 8'hff);
    rd(IDX_TEST0, 8'h00, "test register");
    rd(8'h3f, 8'h00, "unmapped");
    $display("test reset done");
    @(posedge clk_i) bad_access_i <= 1'b1;
    @(posedge clk_i) bad_access_i <= 1'b0;
    wr(IDX_FLAGS, 8'h00);
    rd(IDX_FLAGS, 8'h44, "flags write zero");
    trim_factory_i <= 9'($urandom);
    @(posedge clk_i) rst_i <= 1'b1;
    @(posedge clk_i) rst_i <= 1'b0;
    rd(IDX_FLAGS, 8'h44, "flags after system reset");
    rd(IDX_TRIML, trim_factory_i[7:0], "trim reload");
    bus(1'b1, IDX_FLAGS, 8'h44, 4'h0, 1'b0);
    rd(IDX_FLAGS, 8'h44, "flags no lane");
    wr(IDX_FLAGS, 8'hff);
    rd(IDX_FLAGS, 8'h00, "flags write one");
    $display("test flags done");
    for (int i = 0; i < 3; i++) begin
      r = (i == 0) ? 0 : (i == 1) ? 127 : int'($urandom_range(126, 1));
      wr(IDX_DCO_RATIO_FIELD, 8'(r));
      tick(1);
      compare("loop factor", 32'(1000 + 2 * r), {21'h0, clk_cfg_o.dco_ratio});
    end
    v = 8'($urandom);
    wr(IDX_TRIMH, 8'hff);
    wr(IDX_TRIML, v);
    tick(1);
    compare("ref trim", {23'h0, 1'b1, v}, {23'h0, clk_cfg_o.ref_trim});
    rd(IDX_TRIMH, 8'h01, "trim high reserved");
    $display("test ratio and trim done");
    wr(IDX_CTL1, 8'h52);
    rd(IDX_CTL1, 8'h52, "control 1");
    compare("bus divider", 32'h5, {28'h0, clk_cfg_o.bus_divider});
    @(posedge clk_i) fll_in_tol_i <= 1'b1;
    tick(2);
    compare("lock irq", 32'h1, {31'h0, irq_o});
    wr(IDX_FLAGS, 8'h08);
    rd(IDX_FLAGS, 8'h18, "lock flags");
    wr(IDX_CTL1, 8'h00);
    tick(1);
    compare("lock irq gated", 32'h0, {31'h0, irq_o});
    regs = '{IDX_CTL0, IDX_DCO_RATIO_FIELD, IDX_TRIMH, IDX_TRIML};
    foreach (regs[k]) begin
      wr(IDX_FLAGS, 8'h10);
      wr(regs[k], 8'h00);
      fll_in_tol_i <= 1'b0;
      rd(IDX_FLAGS, 8'h00, "silent lock clear");
      @(posedge clk_i) fll_in_tol_i <= 1'b1;
      tick(2);
    end
    wr(IDX_FLAGS, 8'h10);
    @(posedge clk_i) stop_mode_i <= 1'b1;
    @(posedge clk_i) stop_mode_i <= 1'b0;
    fll_in_tol_i <= 1'b0;
    rd(IDX_FLAGS, 8'h00, "stop lock clear");
    @(posedge clk_i) fll_in_tol_i <= 1'b1;
    tick(2);
    bus(1'b1, IDX_FLAGS, 8'h10, 4'hf, 1'b1);
    rd(IDX_FLAGS, 8'h10, "set beats clear");
    $display("test lock done");
    wr(IDX_FLAGS, 8'h10);
    wr(IDX_CTL0, 8'h8c);
    rd(IDX_CTL0, 8'h80, "select before start");
    compare("monitor off", 32'h0, {31'h0, clk_cfg_o.osc_monitor_en});
    compare("osc enable", 32'h1, {31'h0, clk_cfg_o.osc_enable});
    osc_ready_i <= 1'b1;
    tick(2);
    rd(IDX_FLAGS, 8'h02, "osc started");
    compare("monitor on", 32'h1, {31'h0, clk_cfg_o.osc_monitor_en});
    wr(IDX_CTL0, 8'h8c);
    tick(1);
    compare("ref select", 32'h1, {31'h0, clk_cfg_o.loop_reference_select});
    compare("bus source", 32'h1, {31'h0, clk_cfg_o.bus_clk_source_sel});
    @(posedge clk_i) stop_mode_i <= 1'b1;
    osc_ready_i <= 1'b0;
    @(posedge clk_i) stop_mode_i <= 1'b0;
    tick(2);
    rd(IDX_FLAGS, 8'h00, "osc stop");
    rd(IDX_CTL0, 8'h80, "selects stop");
    $display("test oscillator done");
    wr(IDX_EVT_STAT, 8'h07);
    wr(IDX_EVT_MASK, 8'h02);
    @(posedge clk_i) bad_access_i <= 1'b1;
    @(posedge clk_i) bad_access_i <= 1'b0;
    tick(2);
    compare("event irq", 32'h1, {31'h0, irq_o});
    rd(IDX_EVT_STAT, 8'h02, "event status");
    wr(IDX_EVT_STAT, 8'h02);
    tick(1);
    compare("event irq clear", 32'h0, {31'h0, irq_o});
    $display("test interrupt done");
    final_report();
  end
endmodule : test_fct_clock_status
